/* rtl/touch_adc_control.v */
/*
  Converter control for a touch screen interface: serial register access,
  function sequencing, averaging, conversion clock, panel settling on scans, result
  store with data-available tracking, contrast converter power down.
  Assumes a converter macro presenting adc_code on the clk domain and a
  touch detector on the clk domain; serial pins are asynchronous.
*/
`include "touch_adc_control_defines.vh"

module touch_adc_control #(
  parameter US_TICK = `US_TICK_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Serial port pins
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        mosi,
  output reg         miso_r,
  output reg         miso_oe_r,
  // Touch detector and converter macro
  input  wire        touch_detect,
  input  wire [11:0] adc_code,
  output reg         adc_power_r,
  output reg  [3:0]  adc_channel_r,
  // Panel drivers
  output reg         drv_xp_r,
  output reg         drv_xm_r,
  output reg         drv_yp_r,
  output reg         drv_ym_r,
  // Data available pin, active low
  output reg         data_available_n_r,
  // Contrast converter
  output reg         contrast_dac_powerdown_r,
  output reg         contrast_output_en_r
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_WAIT   = 3'd1;
  localparam ST_SETTLE = 3'd2;
  localparam ST_CONV   = 3'd3;
  localparam ST_STORE  = 3'd4;
  localparam ST_DRIVE  = 3'd5;

  // ===================================================================
  // Pin synchronisers
  reg sclk_s1, sclk_s2, sclk_s3, cs_n_s1, cs_n_s2, mosi_s1, mosi_s2;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1 <= 1'b0; sclk_s2 <= 1'b0; sclk_s3 <= 1'b0;
      cs_n_s1 <= 1'b1; cs_n_s2 <= 1'b1;
      mosi_s1 <= 1'b0; mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk; sclk_s2 <= sclk_s1; sclk_s3 <= sclk_s2;
      cs_n_s1 <= cs_n; cs_n_s2 <= cs_n_s1;
      mosi_s1 <= mosi; mosi_s2 <= mosi_s1;
    end
  end
  wire sel   = ~cs_n_s2;
  wire s_ris = sel & sclk_s2 & ~sclk_s3;
  wire s_fal = sel & ~sclk_s2 & sclk_s3;

  // ===================================================================
  // Serial frame: 16-bit command then 16-bit data
  reg  [5:0]  bit_cnt_r;
  reg  [15:0] shift_r;
  reg  [15:0] cmd_r;
  reg  [15:0] rd_data_r;
  wire [15:0] shift_nxt = {shift_r[14:0], mosi_s2};
  wire        cmd_done  = s_ris & (bit_cnt_r == `FRAME_CMD_LAST);
  wire        data_done = s_ris & (bit_cnt_r == `FRAME_DATA_LAST);
  wire        is_rd_nxt = shift_nxt[`CMD_READ_BIT];
  wire [3:0]  pg_nxt    = shift_nxt[`CMD_PAGE_HI:`CMD_PAGE_LO];
  wire [5:0]  ad_nxt    = shift_nxt[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire        wr_any    = data_done & ~cmd_r[`CMD_READ_BIT]
                          & (cmd_r[`CMD_PAGE_HI:`CMD_PAGE_LO] == `PAGE_CONTROL);
  wire        wr_ctrl   = wr_any & (cmd_r[`CMD_ADDR_HI:`CMD_ADDR_LO] == `ADDR_CONV_CTRL);
  wire        wr_dac    = wr_any & (cmd_r[`CMD_ADDR_HI:`CMD_ADDR_LO] == `ADDR_CONTRAST_DAC);
  wire        rd_result = cmd_done & is_rd_nxt & (pg_nxt == `PAGE_RESULTS);

  // ===================================================================
  // Control register fields
  reg        touch_mode_r;
  reg [3:0]  func_r;
  reg [1:0]  res_r, avg_r, cclk_r;
  reg [2:0]  settle_r;
  reg [2:0]  state_r;
  wire       start_req = wr_ctrl & ~shift_nxt[`STATUS_STOP_BIT];
  wire       stop_req  = wr_ctrl & shift_nxt[`STATUS_STOP_BIT];
  wire       busy      = (state_r == ST_SETTLE) | (state_r == ST_CONV) | (state_r == ST_STORE);
  wire [15:0] ctrl_rd  = {touch_detect, ~busy, func_r, res_r, avg_r, cclk_r, settle_r, 1'b0};

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      touch_mode_r             <= 1'b0;
      func_r                   <= `RST_FUNC;
      res_r                    <= `RST_RES;
      avg_r                    <= `RST_AVG;
      cclk_r                   <= `RST_CLK;
      settle_r                 <= `RST_SETTLE;
      contrast_dac_powerdown_r <= `RST_CONTRAST_PD;
      contrast_output_en_r     <= ~`RST_CONTRAST_PD;
    end else begin
      if (wr_ctrl) begin
        touch_mode_r <= shift_nxt[`TOUCH_MODE_BIT];
        func_r       <= shift_nxt[`FUNC_HI:`FUNC_LO];
        res_r        <= shift_nxt[`RES_HI:`RES_LO];
        avg_r        <= shift_nxt[`AVG_HI:`AVG_LO];
        cclk_r       <= shift_nxt[`CLK_HI:`CLK_LO];
        settle_r     <= shift_nxt[`SETTLE_HI:`SETTLE_LO];
      end
      if (wr_dac) begin
        contrast_dac_powerdown_r <= shift_nxt[`CONTRAST_PD_BIT];
        contrast_output_en_r     <= ~shift_nxt[`CONTRAST_PD_BIT];
      end
    end
  end

  // ===================================================================
  // Result store and data-available tracking
  reg [11:0] result_mem [0:15];
  reg [15:0] updated_r;
  reg [15:0] set_mask;
  wire [15:0] clr_mask = rd_result ? (16'h0001 << ad_nxt[3:0]) : 16'h0000;
  wire [15:0] rd_word  = (pg_nxt == `PAGE_RESULTS) ? {4'h0, result_mem[ad_nxt[3:0]]} :
                         (pg_nxt != `PAGE_CONTROL) ? 16'h0000 :
                         (ad_nxt == `ADDR_CONV_CTRL) ? ctrl_rd :
                         (ad_nxt == `ADDR_CONTRAST_DAC) ? {contrast_dac_powerdown_r, 15'h0000} : 16'h0000;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 6'd0; shift_r <= 16'h0000; cmd_r <= 16'h0000;
      rd_data_r <= 16'h0000; miso_r <= 1'b0; miso_oe_r <= 1'b0;
    end else if (!sel) begin
      bit_cnt_r <= 6'd0;
      miso_oe_r <= 1'b0;
    end else begin
      if (s_ris) begin
        shift_r <= shift_nxt;
        if (bit_cnt_r != `FRAME_DATA_LAST)
          bit_cnt_r <= bit_cnt_r + 6'd1;
        if (cmd_done) begin
          cmd_r     <= shift_nxt;
          rd_data_r <= rd_word;
        end
      end
      if (s_fal && bit_cnt_r > `FRAME_CMD_LAST && cmd_r[`CMD_READ_BIT]) begin
        miso_r    <= rd_data_r[15];
        miso_oe_r <= 1'b1;
        rd_data_r <= {rd_data_r[14:0], 1'b0};
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      updated_r          <= 16'h0000;
      data_available_n_r <= 1'b1;
    end else begin
      updated_r          <= (updated_r & ~clr_mask) | set_mask;
      data_available_n_r <= ~|((updated_r & ~clr_mask) | set_mask);
    end
  end

  // ===================================================================
  // Sequencing helpers
  function [3:0] seq_chan;
    input [3:0] f;
    input [1:0] k;
    begin
      case (f)
        `FN_SCAN_XY:   seq_chan = k[0] ? `CH_Y : `CH_X;
        `FN_SCAN_XYZ:  seq_chan = {2'b00, k};
        `FN_X:         seq_chan = `CH_X;
        `FN_Y:         seq_chan = `CH_Y;
        `FN_Z:         seq_chan = k[0] ? `CH_Z2 : `CH_Z1;
        `FN_BATTERY_ONE_RESULT:      seq_chan = `CH_BATTERY_ONE_RESULT;
        `FN_BATTERY_TWO_RESULT:      seq_chan = `CH_BATTERY_TWO_RESULT;
        `FN_AUXILIARY_ONE_RESULT:      seq_chan = `CH_AUXILIARY_ONE_RESULT;
        `FN_AUXILIARY_TWO_RESULT:      seq_chan = `CH_AUXILIARY_TWO_RESULT;
        `FN_TEMP1:     seq_chan = `CH_TEMP1;
        `FN_PORT_SCAN: seq_chan = `CH_BATTERY_ONE_RESULT + {2'b00, k};
        `FN_TEMP2:     seq_chan = `CH_TEMP2;
        default:       seq_chan = `CH_X;
      endcase
    end
  endfunction

  function [1:0] seq_last;
    input [3:0] f;
    begin
      case (f)
        `FN_SCAN_XY, `FN_Z:          seq_last = 2'd1;
        `FN_SCAN_XYZ, `FN_PORT_SCAN: seq_last = 2'd3;
        default:                     seq_last = 2'd0;
      endcase
    end
  endfunction

  function [16:0] settle_us;
    input [2:0] s;
    begin
      case (s)
        3'd0:    settle_us = `SETTLE_0_US;
        3'd1:    settle_us = `SETTLE_1_US;
        3'd2:    settle_us = `SETTLE_2_US;
        3'd3:    settle_us = `SETTLE_3_US;
        3'd4:    settle_us = `SETTLE_4_US;
        3'd5:    settle_us = `SETTLE_5_US;
        3'd6:    settle_us = `SETTLE_6_US;
        default: settle_us = `SETTLE_7_US;
      endcase
    end
  endfunction

  wire [3:0]  res_bits  = (res_r == 2'b01) ? 4'd8 : (res_r == 2'b10) ? 4'd10 : 4'd12;
  wire [11:0] code_res  = (res_r == 2'b01) ? {4'h0, adc_code[11:4]} :
                          (res_r == 2'b10) ? {2'h0, adc_code[11:2]} : adc_code;
  wire [4:0]  avg_total = (avg_r == 2'b01) ? 5'd4 : (avg_r == 2'b10) ? 5'd8 :
                          (avg_r == 2'b11) ? 5'd16 : 5'd1;
  wire [2:0]  avg_shift = (avg_r == 2'b00) ? 3'd0 : {1'b0, avg_r} + 3'd1;
  wire [31:0] div_w     = (cclk_r == 2'b00) ? `DIV_8M : (cclk_r == 2'b01) ? `DIV_4M :
                          (cclk_r == 2'b10) ? `DIV_2M : `DIV_1M;
  wire [7:0]  conv_div  = div_w[7:0];
  wire        scan_fn   = (func_r == `FN_SCAN_XY) | (func_r == `FN_SCAN_XYZ);
  wire        conv_fn   = (func_r != `FN_NONE) & (func_r < `FN_DRV_X);
  wire        go        = start_req & (state_r == ST_IDLE || state_r == ST_DRIVE);

  // ===================================================================
  // Sequencer
  reg [16:0] us_cnt_r;
  reg [11:0] tick_cnt_r;
  reg [7:0]  div_cnt_r;
  reg [4:0]  conv_tick_r;
  reg [4:0]  avg_cnt_r;
  reg [15:0] acc_r;
  reg [1:0]  step_r;
  wire [3:0]  chan      = seq_chan(func_r, step_r);
  wire [15:0] avg_value = acc_r >> avg_shift;

  always @* begin
    set_mask = 16'h0000;
    if (state_r == ST_STORE)
      set_mask = 16'h0001 << chan;
  end

  always @(posedge clk) begin
    if (state_r == ST_STORE)
      result_mem[chan] <= avg_value[11:0];
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE; us_cnt_r <= 17'd0; tick_cnt_r <= 12'd0; div_cnt_r <= 8'd0;
      conv_tick_r <= 5'd0; avg_cnt_r <= 5'd0; acc_r <= 16'h0000; step_r <= 2'd0;
      adc_power_r <= 1'b0; adc_channel_r <= 4'h0;
      drv_xp_r <= 1'b0; drv_xm_r <= 1'b0; drv_yp_r <= 1'b0; drv_ym_r <= 1'b0;
    end else if (stop_req) begin
      state_r     <= ST_IDLE;
      adc_power_r <= 1'b0;
      drv_xp_r <= 1'b0; drv_xm_r <= 1'b0; drv_yp_r <= 1'b0; drv_ym_r <= 1'b0;
    end else if (go) begin
      step_r   <= 2'd0;
      drv_xp_r <= 1'b0; drv_xm_r <= 1'b0; drv_yp_r <= 1'b0; drv_ym_r <= 1'b0;
      case (shift_nxt[`FUNC_HI:`FUNC_LO])
        `FN_NONE: state_r <= ST_IDLE;
        `FN_SCAN_XY, `FN_SCAN_XYZ: state_r <= ST_WAIT;
        `FN_DRV_X: begin
          state_r <= ST_DRIVE; drv_xp_r <= 1'b1; drv_xm_r <= 1'b1;
        end
        `FN_DRV_Y: begin
          state_r <= ST_DRIVE; drv_yp_r <= 1'b1; drv_ym_r <= 1'b1;
        end
        `FN_DRV_YX: begin
          state_r <= ST_DRIVE; drv_yp_r <= 1'b1; drv_xm_r <= 1'b1;
        end
        default: begin
          state_r <= ST_SETTLE; us_cnt_r <= 17'd0; tick_cnt_r <= 12'd0;
        end
      endcase
    end else begin
      case (state_r)
        ST_WAIT: begin
          if (touch_detect) begin
            state_r    <= ST_SETTLE;
            us_cnt_r   <= 17'd0;
            tick_cnt_r <= 12'd0;
          end
        end
        ST_SETTLE: begin
          adc_channel_r <= chan;
          drv_xp_r <= (chan == `CH_X);
          drv_xm_r <= (chan == `CH_X) | (chan == `CH_Z1) | (chan == `CH_Z2);
          drv_yp_r <= (chan == `CH_Y) | (chan == `CH_Z1) | (chan == `CH_Z2);
          drv_ym_r <= (chan == `CH_Y);
          if (us_cnt_r >= settle_us(settle_r) || !scan_fn || step_r != 2'd0) begin
            state_r     <= ST_CONV;
            adc_power_r <= 1'b1;
            div_cnt_r   <= 8'd0;
            conv_tick_r <= 5'd0;
            avg_cnt_r   <= 5'd0;
            acc_r       <= 16'h0000;
          end else if (tick_cnt_r == US_TICK[11:0] - 12'd1) begin
            tick_cnt_r <= 12'd0;
            us_cnt_r   <= us_cnt_r + 17'd1;
          end else begin
            tick_cnt_r <= tick_cnt_r + 12'd1;
          end
        end
        ST_CONV: begin
          if (div_cnt_r == conv_div - 8'd1) begin
            div_cnt_r <= 8'd0;
            if (conv_tick_r == {1'b0, res_bits} + 5'd`CONV_EXTRA_TICKS - 5'd1) begin
              conv_tick_r <= 5'd0;
              acc_r       <= acc_r + {4'h0, code_res};
              avg_cnt_r   <= avg_cnt_r + 5'd1;
              if (avg_cnt_r == avg_total - 5'd1)
                state_r <= ST_STORE;
            end else begin
              conv_tick_r <= conv_tick_r + 5'd1;
            end
          end else begin
            div_cnt_r <= div_cnt_r + 8'd1;
          end
        end
        ST_STORE: begin
          if (step_r != seq_last(func_r)) begin
            step_r  <= step_r + 2'd1;
            state_r <= ST_SETTLE;
          end else begin
            step_r      <= 2'd0;
            adc_power_r <= 1'b0;
            drv_xp_r <= 1'b0; drv_xm_r <= 1'b0; drv_yp_r <= 1'b0; drv_ym_r <= 1'b0;
            state_r     <= (scan_fn && touch_detect) ? ST_SETTLE : (scan_fn ? ST_WAIT : ST_IDLE);
            us_cnt_r    <= 17'd0;
            tick_cnt_r  <= 12'd0;
          end
        end
        ST_DRIVE: state_r <= ST_DRIVE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // touch_adc_control

/* rtl/touch_adc_control_defines.vh */
/*
  Constants for the touch converter control block: serial command layout,
  register addresses, field positions, reset values and timing counts.
  Assumes inclusion by touch_adc_control.v only; definitions only.
*/
`ifndef TOUCH_ADC_CONTROL_DEFINES_VH
`define TOUCH_ADC_CONTROL_DEFINES_VH

// =====================================================================
// Serial command word
`define CMD_READ_BIT        15
`define CMD_PAGE_HI         14
`define CMD_PAGE_LO         11
`define CMD_ADDR_HI         10
`define CMD_ADDR_LO         5
`define FRAME_CMD_LAST      6'd15
`define FRAME_DATA_LAST     6'd31

// =====================================================================
// Register map
`define PAGE_RESULTS        4'h0
`define PAGE_CONTROL        4'h1
`define ADDR_CONV_CTRL      6'h00
`define ADDR_CONTRAST_DAC   6'h02

// =====================================================================
// Converter control fields
`define TOUCH_MODE_BIT      15
`define STATUS_STOP_BIT     14
`define FUNC_HI             13
`define FUNC_LO             10
`define RES_HI              9
`define RES_LO              8
`define AVG_HI              7
`define AVG_LO              6
`define CLK_HI              5
`define CLK_LO              4
`define SETTLE_HI           3
`define SETTLE_LO           1
`define CONTRAST_PD_BIT     15

// =====================================================================
// Reset values
`define RST_FUNC            4'h0
`define RST_RES             2'h0
`define RST_AVG             2'h0
`define RST_CLK             2'h0
`define RST_SETTLE          3'h0
`define RST_CONTRAST_PD     1'b0

// =====================================================================
// Function codes
`define FN_NONE             4'h0
`define FN_SCAN_XY          4'h1
`define FN_SCAN_XYZ         4'h2
`define FN_X                4'h3
`define FN_Y                4'h4
`define FN_Z                4'h5
`define FN_BATTERY_ONE_RESULT             4'h6
`define FN_BATTERY_TWO_RESULT             4'h7
`define FN_AUXILIARY_ONE_RESULT             4'h8
`define FN_AUXILIARY_TWO_RESULT             4'h9
`define FN_TEMP1            4'ha
`define FN_PORT_SCAN        4'hb
`define FN_TEMP2            4'hc
`define FN_DRV_X            4'hd
`define FN_DRV_Y            4'he
`define FN_DRV_YX           4'hf

// =====================================================================
// Result register indices (page 0 addresses, also converter channel)
`define CH_X                4'h0
`define CH_Y                4'h1
`define CH_Z1               4'h2
`define CH_Z2               4'h3
`define CH_BATTERY_ONE_RESULT             4'h4
`define CH_BATTERY_TWO_RESULT             4'h5
`define CH_AUXILIARY_ONE_RESULT             4'h6
`define CH_AUXILIARY_TWO_RESULT             4'h7
`define CH_TEMP1            4'h8
`define CH_TEMP2            4'h9

// =====================================================================
// Timing
`define CLK_MHZ             200
`define US_TICK_CYCLES      (`CLK_MHZ)
`define CONV_CLK_8M_MHZ     8
`define CONV_CLK_4M_MHZ     4
`define CONV_CLK_2M_MHZ     2
`define CONV_CLK_1M_MHZ     1
`define DIV_8M              (`CLK_MHZ / `CONV_CLK_8M_MHZ)
`define DIV_4M              (`CLK_MHZ / `CONV_CLK_4M_MHZ)
`define DIV_2M              (`CLK_MHZ / `CONV_CLK_2M_MHZ)
`define DIV_1M              (`CLK_MHZ / `CONV_CLK_1M_MHZ)
`define CONV_EXTRA_TICKS    1
`define SETTLE_0_US         0
`define SETTLE_1_US         100
`define SETTLE_2_US         500
`define SETTLE_3_US         1000
`define SETTLE_4_US         5000
`define SETTLE_5_US         10000
`define SETTLE_6_US         50000
`define SETTLE_7_US         100000

`endif

/* verification/host_spi_model.sv */
/*
  Host processor model: 32-rise serial frames, mode 0, 125 ns clock.
  Assumes the device answers on miso only while its enable is high.
*/
module host_spi_model (
  // Host pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // Device pins
  input  wire  miso,
  input  wire  miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ===================================================================
  // One frame: command word then data word, read data captured
  task automatic frame(input logic [31:0] w, output logic [15:0] r);
    r = 16'h0000;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = w[i];
      #62.5;
      sclk = 1'b1;
      if (i < 16) r = {r[14:0], miso_oe ? miso : 1'bx};
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    cs_n = 1'b1;
    // Released line does not keep the last bit
    mosi = ~mosi;
    #40;
  endtask
endmodule // host_spi_model

/* verification/touch_adc_control_sva.sv */
/*
  Port checks for the touch converter control block.
  Assumes binding to touch_adc_control; one clk domain, rstn async low.
*/
module touch_adc_control_sva #(
  parameter US_TICK = 200
) (
  // Clock and reset
  input wire       clk,
  input wire       rstn,
  // Serial pins
  input wire       cs_n,
  input wire       miso_oe_r,
  // Converter and panel
  input wire       adc_power_r,
  input wire [3:0] adc_channel_r,
  input wire       drv_xp_r,
  input wire       drv_xm_r,
  input wire       drv_yp_r,
  input wire       drv_ym_r,
  // Status and contrast
  input wire       data_available_n_r,
  input wire       contrast_dac_powerdown_r,
  input wire       contrast_output_en_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ===================================================================
  // Properties
  property p_reset_idle;
    $rose(rstn) |-> data_available_n_r && !miso_oe_r && contrast_output_en_r;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("state after reset wrong");

  property p_pd_float;
    contrast_dac_powerdown_r [*2] |-> !contrast_output_en_r;
  endproperty
  a_pd_float: assert property (p_pd_float)
    else $error("contrast output driven while powered down");

  property p_pd_drive;
    !contrast_dac_powerdown_r [*2] |-> contrast_output_en_r;
  endproperty
  a_pd_drive: assert property (p_pd_drive)
    else $error("contrast output floating while powered");

  property p_drv_pairs;
    !(drv_xp_r && drv_yp_r) && !(drv_xm_r && drv_ym_r);
  endproperty
  a_drv_pairs: assert property (p_drv_pairs)
    else $error("conflicting panel drivers on");

  property p_dav_release;
    $rose(data_available_n_r) |-> !cs_n;
  endproperty
  a_dav_release: assert property (p_dav_release)
    else $error("data available released outside a read");

  property p_miso_idle;
    cs_n [*6] |-> !miso_oe_r;
  endproperty
  a_miso_idle: assert property (p_miso_idle)
    else $error("miso driven while deselected");

  property p_miso_frame;
    $rose(miso_oe_r) |-> !cs_n && $past(!cs_n, 3);
  endproperty
  a_miso_frame: assert property (p_miso_frame)
    else $error("miso enabled outside a frame");

  property p_channel_range;
    adc_power_r |-> adc_channel_r <= 4'h9;
  endproperty
  a_channel_range: assert property (p_channel_range)
    else $error("converter channel out of range");
endmodule // touch_adc_control_sva

bind touch_adc_control touch_adc_control_sva #(.US_TICK(US_TICK)) i_touch_adc_control_sva (
  .clk                      (clk),
  .rstn                     (rstn),
  .cs_n                     (cs_n),
  .miso_oe_r                (miso_oe_r),
  .adc_power_r              (adc_power_r),
  .adc_channel_r            (adc_channel_r),
  .drv_xp_r                 (drv_xp_r),
  .drv_xm_r                 (drv_xm_r),
  .drv_yp_r                 (drv_yp_r),
  .drv_ym_r                 (drv_ym_r),
  .data_available_n_r       (data_available_n_r),
  .contrast_dac_powerdown_r (contrast_dac_powerdown_r),
  .contrast_output_en_r     (contrast_output_en_r)
);

/* verification/touch_adc_control_tb_top.sv */
/*
  Self-checking bench: register access, conversions, timing, drivers, scan.
  Assumes host_spi_model and the checker are compiled first.
*/
module touch_adc_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int US_TICK = 2;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        touch_detect = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic [15:0] seed = 16'h8581;
  logic [5:0]  tcase [6] = '{6'h14, 6'h21, 6'h36, 6'h13, 6'h29, 6'h1c};
  int          failures = 0;
  int          comparisons = 0;
  wire         sclk, cs_n, mosi, miso_r, miso_oe_r, adc_power_r;
  wire         drv_xp_r, drv_xm_r, drv_yp_r, drv_ym_r;
  wire         data_available_n_r, contrast_dac_powerdown_r, contrast_output_en_r;
  wire [3:0]   adc_channel_r;

  always #2.5 clk = ~clk;

  touch_adc_control #(.US_TICK(US_TICK)) i_touch_adc_control (
    .clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_r(miso_r),
    .miso_oe_r(miso_oe_r), .touch_detect(touch_detect), .adc_code(adc_code),
    .adc_power_r(adc_power_r), .adc_channel_r(adc_channel_r), .drv_xp_r(drv_xp_r),
    .drv_xm_r(drv_xm_r), .drv_yp_r(drv_yp_r), .drv_ym_r(drv_ym_r),
    .data_available_n_r(data_available_n_r), .contrast_dac_powerdown_r(contrast_dac_powerdown_r),
    .contrast_output_en_r(contrast_output_en_r));

  host_spi_model i_host_spi_model (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_r), .miso_oe(miso_oe_r));

  // ===================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int conv_cyc(input logic [5:0] t);
    int b;
    b = (t[5:4] == 2'b01) ? 9 : (t[5:4] == 2'b10) ? 11 : 13;
    return b * (25 << t[1:0]) * ((t[3:2] == 2'b00) ? 1 : (2 << t[3:2]));
  endfunction

  function automatic logic [9:0] chans(input logic [3:0] f);
    case (f)
      4'h3: return 10'h001;
      4'h4: return 10'h002;
      4'h5: return 10'h00c;
      4'hb: return 10'h0f0;
      4'hc: return 10'h200;
      default: return 10'h010 << (f - 4'h6);
    endcase
  endfunction

  function automatic logic [11:0] res_val(input logic [5:0] t, input logic [11:0] c);
    return (t[5:4] == 2'b01) ? {4'h0, c[11:4]} : (t[5:4] == 2'b10) ? {2'h0, c[11:2]} : c;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] pg, input logic [5:0] ad, input logic [15:0] d);
    logic [15:0] r;
    i_host_spi_model.frame({1'b0, pg, ad, 5'h00, d}, r);
  endtask

  task automatic rd(input logic [3:0] pg, input logic [5:0] ad, output logic [15:0] d);
    i_host_spi_model.frame({1'b1, pg, ad, 5'h00, 16'h0000}, d);
  endtask

  task automatic wait_dav(output int n);
    n = 0;
    while (data_available_n_r !== 1'b0 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30000) begin
      failures++;
      $display("BAD %0t data available timeout", $time);
    end
  endtask

  task automatic wait_pwr(input logic v);
    int k = 0;
    while (adc_power_r !== v && k < 9000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 9000) begin
      failures++;
      $display("BAD %0t converter power timeout", $time);
    end
  endtask

  // Reads every updated result, data available must hold until the last
  task automatic drain(input logic [9:0] m, input logic [11:0] v, input logic cmp);
    logic [15:0] r;
    for (int c = 0; c < 10; c++) begin
      if (m[c]) begin
        chk({15'h0000, data_available_n_r}, 16'h0000, "dav before read");
        rd(4'h0, c[5:0], r);
        if (cmp) chk(r, {4'h0, v}, "result");
      end
    end
    tick(4);
    chk({15'h0000, data_available_n_r}, 16'h0001, "dav after reads");
  endtask

  task automatic give_verdict;
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #700us;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end

  // ===================================================================
  // Main sequence
  initial begin
    logic [15:0] r, w;
    int n, e;
    tick(4);
    rstn = 1'b1;
    tick(4);
    rd(4'h1, 6'h00, r);
    chk(r, 16'h4000, "ctrl after reset");
    for (int i = 0; i < 4; i++) begin
      tick(1);
      seed = lfsr(seed);
      w = (i == 0) ? 16'h83ff : {seed[15:14], 4'h0, seed[9:0]};
      touch_detect = seed[3];
      wr(4'h1, 6'h00, w);
      rd(4'h1, 6'h00, r);
      chk(r, {touch_detect, 1'b1, 4'h0, w[9:1], 1'b0}, "ctrl readback");
    end
    chk({14'h0000, adc_power_r, data_available_n_r}, 16'h0001, "no conversion");
    tick(1);
    touch_detect = 1'b0;
    wr(4'h1, 6'h02, 16'hffff);
    rd(4'h1, 6'h02, r);
    chk(r, 16'h8000, "contrast off readback");
    chk({14'h0000, contrast_dac_powerdown_r, contrast_output_en_r}, 16'h0002, "contrast off");
    wr(4'h1, 6'h02, 16'h7fff);
    rd(4'h1, 6'h02, r);
    chk(r, 16'h0000, "contrast on readback");
    chk({14'h0000, contrast_dac_powerdown_r, contrast_output_en_r}, 16'h0001, "contrast on");
    rd(4'h1, 6'h07, r);
    chk(r, 16'h0000, "unmapped read");
    for (int f = 13; f < 16; f++) begin
      wr(4'h1, 6'h00, {2'b00, f[3:0], 10'h000});
      tick(4);
      e = (f == 13) ? 'h1c : (f == 14) ? 'h13 : 'h16;
      chk({11'h000, data_available_n_r, drv_xp_r, drv_xm_r, drv_yp_r, drv_ym_r}, e[15:0], "drivers");
    end
    wr(4'h1, 6'h00, 16'h4000);
    for (int f = 3; f < 13; f++) begin
      seed = lfsr(seed);
      adc_code = seed[11:0];
      wr(4'h1, 6'h00, {2'b00, f[3:0], 10'h020});
      wait_dav(n);
      wait_pwr(1'b0);
      tick(2);
      drain(chans(f[3:0]), adc_code, 1'b1);
    end
    for (int i = 0; i < 6; i++) begin
      e = conv_cyc(tcase[i]);
      fork
        wr(4'h1, 6'h00, {2'b00, 4'h3, tcase[i], 4'h0});
        begin
          wait_pwr(1'b1);
          wait_dav(n);
        end
      join
      chk({15'h0000, n >= e - 5 && n <= e + 40}, 16'h0001, "conversion time");
      drain(10'h001, res_val(tcase[i], adc_code), 1'b1);
    end
    wr(4'h1, 6'h00, 16'h0422);
    tick(300);
    chk({14'h0000, adc_power_r, data_available_n_r}, 16'h0001, "scan waits for touch");
    touch_detect = 1'b1;
    wait_dav(n);
    e = 100 * US_TICK + 1300;
    chk({15'h0000, n >= e - 5 && n <= e + 60}, 16'h0001, "settle then convert");
    tick(1500);
    wr(4'h1, 6'h00, 16'h4000);
    tick(5);
    chk({15'h0000, adc_power_r}, 16'h0000, "stop powers down");
    tick(50);
    rd(4'h1, 6'h00, r);
    chk(r, 16'hc000, "stopped status");
    tick(1);
    touch_detect = 1'b0;
    drain(10'h003, adc_code, 1'b1);
    touch_detect = 1'b1;
    wr(4'h1, 6'h00, 16'h0800);
    tick(1400);
    touch_detect = 1'b0;
    tick(1400);
    chk({15'h0000, adc_power_r}, 16'h0000, "release ends scan");
    drain(10'h00f, adc_code, 1'b1);
    give_verdict();
  end
endmodule // touch_adc_control_tb_top
